// ---- hw/daa_regs_pkg.sv ----
// Constants for the gain, daisy-chain, filter and calibration register bank.
// Assumes an 8-bit register port from the serial-port frame decoder.
package daa_regs_pkg;

  // Register indices on the register port
  localparam logic [4:0] ADDR_LINE_INFO_AND_COARSE_GAIN = 5'h0d;
  localparam logic [4:0] ADDR_CHAIN_CONTROL = 5'h0e;
  localparam logic [4:0] ADDR_FINE_GAIN_CONTROL = 5'h0f;
  localparam logic [4:0] ADDR_FILTER_TYPE_CONTROL = 5'h10;
  localparam logic [4:0] ADDR_CALIBRATION_CONTROL = 5'h11;

  // Line info and coarse gain fields
  localparam int LINE_VARIANT_BIT = 6;
  localparam int REVISION_MSB = 5;
  localparam int REVISION_LSB = 2;
  localparam int RX_COARSE_BIT = 1;
  localparam int TX_COARSE_BIT = 0;

  // Chain control fields
  localparam int SLAVE_COUNT_MSB = 7;
  localparam int SLAVE_COUNT_LSB = 5;
  localparam int SLOT_SEL_MSB = 4;
  localparam int SLOT_SEL_LSB = 3;
  localparam int SYNC_SPACING_BIT = 2;
  localparam int RING_POL_BIT = 1;
  localparam int CHAIN_EN_BIT = 0;
  localparam logic [7:0] CHAIN_RESET_MODE01 = 8'h02;
  localparam logic [7:0] CHAIN_RESET_MODE2 = 8'h3f;
  localparam logic [1:0] SERIAL_MODE_2 = 2'h2;

  // Slot select encodings
  localparam logic [1:0] SLOT_16BIT = 2'h0;
  localparam logic [1:0] SLOT_15BIT_LSB1 = 2'h2;
  localparam logic [1:0] SLOT_15BIT_LSB0 = 2'h3;

  // Frame-sync spacing in bit-clock periods
  localparam logic [5:0] SYNC_PERIOD_WIDE = 6'h20;
  localparam logic [5:0] SYNC_PERIOD_NARROW = 6'h10;

  // Fine gain fields
  localparam int TX_MUTE_BIT = 7;
  localparam int TX_STEP_MSB = 6;
  localparam int TX_STEP_LSB = 4;
  localparam int RX_MUTE_BIT = 3;
  localparam int RX_STEP_MSB = 2;
  localparam int RX_STEP_LSB = 0;
  localparam logic [3:0] GAIN_STEP_DB = 4'h3;
  localparam logic [3:0] GAIN_MAX_DB = 4'hc;

  // Filter register
  localparam int FILTER_SEL_BIT = 4;
  localparam logic [3:0] FILTER_LOW_FIXED = 4'h8;
  localparam logic [7:0] FILTER_RESET = 8'h08;

  // Calibration register
  localparam int MANUAL_CAL_BIT = 6;
  localparam int AUTO_CAL_DIS_BIT = 5;

endpackage

// ---- hw/daa_gain_chain_filter_regs.sv ----
// Gain, daisy-chain, filter and calibration registers of the host-side chip.
// Assumes the register port is driven by the serial-port decoder on clk_i;
// mode-select and request pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none

module daa_gain_chain_filter_regs
  import daa_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [1:0] mode_select_i,
  input wire logic line_variant_flag_i,
  input wire logic [3:0] line_side_revision_i,
  input wire logic ring_detect_i,
  input wire logic delayed_sync_i,
  input wire logic request_or_ring_pin_i,
  output logic request_or_ring_pin_o,
  output logic request_or_ring_pin_oe_o,
  output logic ring_or_delayed_sync_pin_o,
  output logic secondary_request_o,
  output logic rx_coarse_boost_o,
  output logic tx_coarse_cut_o,
  output logic transmit_mute_o,
  output logic [3:0] transmit_attenuation_db_o,
  output logic receive_mute_o,
  output logic [3:0] receive_gain_db_o,
  output logic chain_enable_o,
  output logic [2:0] slave_count_o,
  output logic serial_out_lsb_force_o,
  output logic serial_out_lsb_value_o,
  output logic [5:0] frame_sync_period_o,
  output logic recursive_filter_select_o,
  output logic manual_cal_trigger_o,
  output logic auto_cal_disable_o
);

  typedef struct packed {
    // Synchronisers
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic req_s1;
    logic req_s2;
    // Register contents
    logic rx_coarse_boost;
    logic tx_coarse_cut;
    logic [7:0] chain;
    logic [7:0] fine;
    logic recursive_filter_select;
    logic manual_cal;
    logic auto_cal_disable;
    // Output copies
    logic [7:0] rdata;
    logic cal_pulse;
    logic req_pin_o;
    logic req_pin_oe;
    logic sync_pin_o;
    logic secondary_request;
    logic rx_boost_out;
    logic tx_cut_out;
    logic tx_mute;
    logic [3:0] tx_att_db;
    logic rx_mute;
    logic [3:0] rx_gain_db;
    logic chain_en;
    logic [2:0] slaves;
    logic lsb_force;
    logic lsb_value;
    logic [5:0] sync_period;
    logic filter_out;
    logic auto_cal_out;
  } state_t;

  state_t state_q;
  state_t state_d;

  // Fine gain step to dB: codes with the top bit set saturate
  function automatic logic [3:0] step_to_db(input logic [2:0] code);
    logic [3:0] db;
    db = GAIN_MAX_DB;
    if (!code[2])
    begin
      db = 4'((GAIN_STEP_DB * code[1:0]));
    end
    return db;
  endfunction

  logic chain_on;
  logic [1:0] slot_sel;

  always_comb
  begin
    state_d = state_q;
    chain_on = 1'b0;
    slot_sel = 2'h0;

    // Pins cross into clk_i through two stages
    // Only the second stage is read by logic, so no metastable level leaks
    state_d.mode_s1 = mode_select_i;
    state_d.mode_s2 = state_q.mode_s1;
    state_d.req_s1 = request_or_ring_pin_i;
    state_d.req_s2 = state_q.req_s1;

    state_d.cal_pulse = 1'b0;

    // Register writes
    if (reg_write_i)
    begin
      case (reg_addr_i)
        ADDR_LINE_INFO_AND_COARSE_GAIN:
        begin
          state_d.rx_coarse_boost = reg_wdata_i[RX_COARSE_BIT];
          state_d.tx_coarse_cut = reg_wdata_i[TX_COARSE_BIT];
        end
        ADDR_CHAIN_CONTROL:
        begin
          state_d.chain = reg_wdata_i;
        end
        ADDR_FINE_GAIN_CONTROL:
        begin
          state_d.fine = reg_wdata_i;
        end
        ADDR_FILTER_TYPE_CONTROL:
        begin
          // Only the select bit is stored; the fixed pattern is not writable
          state_d.recursive_filter_select = reg_wdata_i[FILTER_SEL_BIT];
        end
        ADDR_CALIBRATION_CONTROL:
        begin
          // Trigger fires on every write with bit 6 set, even if already set
          state_d.manual_cal = reg_wdata_i[MANUAL_CAL_BIT];
          state_d.cal_pulse = reg_wdata_i[MANUAL_CAL_BIT];
          state_d.auto_cal_disable = reg_wdata_i[AUTO_CAL_DIS_BIT];
        end
        default:
        begin
          // Other banks own the remaining addresses
          state_d.chain = state_q.chain;
        end
      endcase
    end

    // Register reads; read data holds until the next read
    if (reg_read_i)
    begin
      case (reg_addr_i)
        ADDR_LINE_INFO_AND_COARSE_GAIN:
        begin
          state_d.rdata = 8'h00;
          state_d.rdata[LINE_VARIANT_BIT] = line_variant_flag_i;
          state_d.rdata[REVISION_MSB:REVISION_LSB] = line_side_revision_i;
          state_d.rdata[RX_COARSE_BIT] = state_q.rx_coarse_boost;
          state_d.rdata[TX_COARSE_BIT] = state_q.tx_coarse_cut;
        end
        ADDR_CHAIN_CONTROL:
        begin
          state_d.rdata = state_q.chain;
        end
        ADDR_FINE_GAIN_CONTROL:
        begin
          state_d.rdata = state_q.fine;
        end
        ADDR_FILTER_TYPE_CONTROL:
        begin
          state_d.rdata = {3'h0, state_q.recursive_filter_select, FILTER_LOW_FIXED};
        end
        ADDR_CALIBRATION_CONTROL:
        begin
          state_d.rdata = 8'h00;
          state_d.rdata[MANUAL_CAL_BIT] = state_q.manual_cal;
          state_d.rdata[AUTO_CAL_DIS_BIT] = state_q.auto_cal_disable;
        end
        default:
        begin
          // Unmapped here: other banks answer for their own addresses
          state_d.rdata = 8'h00;
        end
      endcase
    end

    // Chain fields take effect only while chaining is on
    chain_on = state_q.chain[CHAIN_EN_BIT];
    slot_sel = state_q.chain[SLOT_SEL_MSB:SLOT_SEL_LSB];
    state_d.chain_en = chain_on;
    // Defaults stand whenever chaining is off
    state_d.slaves = 3'h0;
    state_d.lsb_force = 1'b0;
    state_d.lsb_value = 1'b0;
    state_d.sync_period = SYNC_PERIOD_WIDE;

    if (chain_on)
    begin
      state_d.slaves = state_q.chain[SLAVE_COUNT_MSB:SLAVE_COUNT_LSB];
      if (state_q.chain[SYNC_SPACING_BIT])
      begin
        state_d.sync_period = SYNC_PERIOD_NARROW;
      end
      case (slot_sel)
        SLOT_16BIT:
        begin
          state_d.lsb_force = 1'b0;
          state_d.lsb_value = 1'b0;
        end
        SLOT_15BIT_LSB1:
        begin
          state_d.lsb_force = 1'b1;
          state_d.lsb_value = 1'b1;
        end
        SLOT_15BIT_LSB0:
        begin
          state_d.lsb_force = 1'b1;
          state_d.lsb_value = 1'b0;
        end
        default:
        begin
          // Reserved code 01: no forced bit, so the word stays 16 bits wide
          state_d.lsb_force = 1'b0;
          state_d.lsb_value = 1'b0;
        end
      endcase
    end

    // Pin roles: chained gives ring on request pin, delayed sync on ring pin
    if (chain_on)
    begin
      state_d.req_pin_oe = 1'b1;
      // Polarity clear keeps the pin active low, like the unchained ring pin
      if (state_q.chain[RING_POL_BIT])
      begin
        state_d.req_pin_o = ring_detect_i;
      end
      else
      begin
        state_d.req_pin_o = !ring_detect_i;
      end
      state_d.sync_pin_o = delayed_sync_i;
      state_d.secondary_request = 1'b0;
    end
    else
    begin
      // Request pin is an input here; its synced level is passed on
      state_d.req_pin_oe = 1'b0;
      state_d.req_pin_o = 1'b0;
      state_d.sync_pin_o = !ring_detect_i;
      state_d.secondary_request = state_q.req_s2;
    end

    // Gain outputs
    state_d.rx_boost_out = state_q.rx_coarse_boost;
    state_d.tx_cut_out = state_q.tx_coarse_cut;
    state_d.tx_mute = state_q.fine[TX_MUTE_BIT];
    state_d.tx_att_db = step_to_db(state_q.fine[TX_STEP_MSB:TX_STEP_LSB]);
    state_d.rx_mute = state_q.fine[RX_MUTE_BIT];
    state_d.rx_gain_db = step_to_db(state_q.fine[RX_STEP_MSB:RX_STEP_LSB]);
    state_d.filter_out = state_q.recursive_filter_select;
    state_d.auto_cal_out = state_q.auto_cal_disable;

    if (rst_i)
    begin
      // Mode pins keep syncing through reset so the default sees a settled mode
      // Fine gain, coarse gain and calibration bits default to zero
      state_d = '0;
      state_d.mode_s1 = mode_select_i;
      state_d.mode_s2 = state_q.mode_s1;
      if (state_q.mode_s2 == SERIAL_MODE_2)
      begin
        state_d.chain = CHAIN_RESET_MODE2;
      end
      else
      begin
        state_d.chain = CHAIN_RESET_MODE01;
      end
      state_d.recursive_filter_select = FILTER_RESET[FILTER_SEL_BIT];
      state_d.sync_period = SYNC_PERIOD_WIDE;
      // Unchained ring pin idles high, as its ring sense is active low
      state_d.sync_pin_o = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_q <= state_d;
  end

  // Register port
  assign reg_rdata_o = state_q.rdata;

  // Pin drivers
  assign request_or_ring_pin_o = state_q.req_pin_o;
  assign request_or_ring_pin_oe_o = state_q.req_pin_oe;
  assign ring_or_delayed_sync_pin_o = state_q.sync_pin_o;
  assign secondary_request_o = state_q.secondary_request;

  // Gain, chain, filter and calibration controls
  assign rx_coarse_boost_o = state_q.rx_boost_out;
  assign tx_coarse_cut_o = state_q.tx_cut_out;
  assign transmit_mute_o = state_q.tx_mute;
  assign transmit_attenuation_db_o = state_q.tx_att_db;
  assign receive_mute_o = state_q.rx_mute;
  assign receive_gain_db_o = state_q.rx_gain_db;
  assign chain_enable_o = state_q.chain_en;
  assign slave_count_o = state_q.slaves;
  assign serial_out_lsb_force_o = state_q.lsb_force;
  assign serial_out_lsb_value_o = state_q.lsb_value;
  assign frame_sync_period_o = state_q.sync_period;
  assign recursive_filter_select_o = state_q.filter_out;
  assign manual_cal_trigger_o = state_q.cal_pulse;
  assign auto_cal_disable_o = state_q.auto_cal_out;

endmodule

`default_nettype wire

// ---- verification/regs_chk_assertions.sv ----
// Port assertions for the gain, chain, filter and calibration registers.
// Assumes one clock, clk_i, and synchronous active-high rst_i.
`timescale 1ns/100ps
`default_nettype none
module regs_chk
  import daa_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic line_variant_flag_i,
  input wire logic [3:0] line_side_revision_i,
  input wire logic request_or_ring_pin_oe_o,
  input wire logic transmit_mute_o,
  input wire logic [3:0] transmit_attenuation_db_o,
  input wire logic [3:0] receive_gain_db_o,
  input wire logic chain_enable_o,
  input wire logic [2:0] slave_count_o,
  input wire logic serial_out_lsb_force_o,
  input wire logic [5:0] frame_sync_period_o,
  input wire logic manual_cal_trigger_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic wf;
  logic wc;
  assign wf = reg_write_i && reg_addr_i == ADDR_FINE_GAIN_CONTROL;
  assign wc = reg_write_i && reg_addr_i == ADDR_CALIBRATION_CONTROL;
  function automatic logic [3:0] db(input logic [2:0] c);
    return c[2] ? 4'hc : 4'h3 * {2'h0, c[1:0]};
  endfunction
  a_tx_mute: assert property (wf |-> ##2 transmit_mute_o == $past(reg_wdata_i[7], 2))
    else $error("tx mute wrong");
  a_tx_step: assert property (wf |-> ##2
    transmit_attenuation_db_o == db($past(reg_wdata_i[6:4], 2))) else $error("tx step wrong");
  a_rx_step: assert property (wf |-> ##2
    receive_gain_db_o == db($past(reg_wdata_i[2:0], 2))) else $error("rx step wrong");
  a_cal_pulse: assert property (wc && reg_wdata_i[6] |=> manual_cal_trigger_o)
    else $error("no cal pulse");
  a_cal_cause: assert property (manual_cal_trigger_o |-> $past(wc && reg_wdata_i[6]))
    else $error("stray cal pulse");
  a_filter_read: assert property (reg_read_i && reg_addr_i == ADDR_FILTER_TYPE_CONTROL
    |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[3:0] == 4'h8) else $error("filter read");
  a_line_read: assert property (reg_read_i && reg_addr_i == ADDR_LINE_INFO_AND_COARSE_GAIN
    |=> reg_rdata_o[7:2] == {1'b0, $past(line_variant_flag_i), $past(line_side_revision_i)})
    else $error("line info read");
  a_chain_off: assert property (!chain_enable_o |-> slave_count_o == 3'h0
    && !serial_out_lsb_force_o && frame_sync_period_o == 6'h20) else $error("chain off");
  a_pin_drive: assert property (request_or_ring_pin_oe_o == chain_enable_o)
    else $error("pin enable");
  cover property (wc && reg_wdata_i[6]);
  cover property (chain_enable_o && frame_sync_period_o == 6'h10);
  cover property (wf ##2 transmit_attenuation_db_o == 4'hc);
endmodule
bind daa_gain_chain_filter_regs regs_chk i_regs_chk (.clk_i, .rst_i, .reg_write_i,
  .reg_read_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .line_variant_flag_i,
  .line_side_revision_i, .request_or_ring_pin_oe_o, .transmit_mute_o,
  .transmit_attenuation_db_o, .receive_gain_db_o, .chain_enable_o, .slave_count_o,
  .serial_out_lsb_force_o, .frame_sync_period_o, .manual_cal_trigger_o);
`default_nettype wire

// ---- verification/dsp_model.sv ----
// Register-port master standing in for the modem DSP.
// Assumes the bench calls put; drives on falling edges only.
`timescale 1ns/100ps
`default_nettype none
module dsp_model (
  input wire logic clk_i,
  output logic reg_write_o,
  output logic reg_read_o,
  output logic [4:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial {reg_write_o, reg_read_o, reg_addr_o, reg_wdata_o} = '0;
  task automatic put(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {reg_write_o, reg_read_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
    @(negedge clk_i);
    // Idle bus shows garbage, so stale words never pass by luck
    {reg_write_o, reg_read_o} = 2'h0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the register bank.
// Assumes dsp_model drives the register port; the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import daa_regs_pkg::*;
  logic clk_i = 0, rst_i = 1, line_variant_flag_i = 1, ring_detect_i = 1, delayed_sync_i = 1;
  logic req_drv = 1, reg_write_i, reg_read_i, request_or_ring_pin_i, request_or_ring_pin_o;
  logic request_or_ring_pin_oe_o, ring_or_delayed_sync_pin_o, secondary_request_o;
  logic rx_coarse_boost_o, tx_coarse_cut_o, transmit_mute_o, receive_mute_o, chain_enable_o;
  logic serial_out_lsb_force_o, serial_out_lsb_value_o, recursive_filter_select_o;
  logic manual_cal_trigger_o, auto_cal_disable_o;
  logic [1:0] mode_select_i = 2'h0;
  logic [3:0] line_side_revision_i = 4'ha, transmit_attenuation_db_o, receive_gain_db_o;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [2:0] slave_count_o;
  logic [5:0] frame_sync_period_o;
  int fails = 0, checks = 0;
  // Shared pin: the bank wins while it drives
  assign request_or_ring_pin_i = request_or_ring_pin_oe_o ? request_or_ring_pin_o : req_drv;
  always #5 clk_i = ~clk_i;
  daa_gain_chain_filter_regs i_daa_gain_chain_filter_regs (.clk_i, .rst_i, .reg_write_i,
    .reg_read_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .mode_select_i, .line_variant_flag_i,
    .line_side_revision_i, .ring_detect_i, .delayed_sync_i, .request_or_ring_pin_i,
    .request_or_ring_pin_o, .request_or_ring_pin_oe_o, .ring_or_delayed_sync_pin_o,
    .secondary_request_o, .rx_coarse_boost_o, .tx_coarse_cut_o, .transmit_mute_o,
    .transmit_attenuation_db_o, .receive_mute_o, .receive_gain_db_o, .chain_enable_o,
    .slave_count_o, .serial_out_lsb_force_o, .serial_out_lsb_value_o, .frame_sync_period_o,
    .recursive_filter_select_o, .manual_cal_trigger_o, .auto_cal_disable_o);
  dsp_model i_dsp_model (.clk_i, .reg_write_o(reg_write_i), .reg_read_o(reg_read_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [3:0] db(input logic [2:0] c);
    return c[2] ? 4'hc : 4'h3 * {2'h0, c[1:0]};
  endfunction
  task wr(input logic [4:0] a, input logic [7:0] v);
    i_dsp_model.put(1'b1, a, v);
  endtask
  task rdc(input logic [4:0] a, input logic [7:0] e);
    i_dsp_model.put(1'b0, a, 8'h00);
    chk("rdata", reg_rdata_o, e);
  endtask
  task settle;
    repeat (2) @(negedge clk_i);
  endtask
  task do_reset(input logic [1:0] m);
    @(negedge clk_i);
    mode_select_i = m;
    rst_i = 1;
    repeat (10) @(negedge clk_i);
    rst_i = 0;
  endtask
  task t_reset;
    logic [7:0] rv [6] = '{8'h68, 8'h02, 8'h00, 8'h08, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
      rdc(5'h0d + 5'(i), rv[i]);
  endtask
  task t_gain;
    wr(ADDR_LINE_INFO_AND_COARSE_GAIN, 8'hff);
    line_variant_flag_i = 0;
    line_side_revision_i = 4'h5;
    settle;
    chk("rx coarse", rx_coarse_boost_o, 1'b1);
    chk("tx coarse", tx_coarse_cut_o, 1'b1);
    rdc(ADDR_LINE_INFO_AND_COARSE_GAIN, 8'h17);
    wr(ADDR_LINE_INFO_AND_COARSE_GAIN, 8'h00);
  endtask
  task t_fine;
    for (int i = 0; i < 8; i++)
    begin
      d = {i[0], 3'(i), !i[0], 3'(7 - i)};
      wr(ADDR_FINE_GAIN_CONTROL, d);
      settle;
      chk("tx mute", transmit_mute_o, d[7]);
      chk("tx db", transmit_attenuation_db_o, db(d[6:4]));
      chk("rx mute", receive_mute_o, d[3]);
      chk("rx db", receive_gain_db_o, db(d[2:0]));
    end
  endtask
  task t_chain;
    logic [7:0] cv [6] = '{8'hfe, 8'h02, 8'h97, 8'hff, 8'h09, 8'h23};
    for (int i = 0; i < 6; i++)
    begin
      d = cv[i];
      ring_detect_i = i[0];
      delayed_sync_i = i[1];
      req_drv = i[0];
      wr(ADDR_CHAIN_CONTROL, d);
      settle;
      chk("slaves", slave_count_o, d[0] ? d[7:5] : 3'h0);
      chk("lsb force", serial_out_lsb_force_o, d[0] & d[4]);
      chk("lsb value", serial_out_lsb_value_o, d[0] & d[4] & !d[3]);
      chk("period", frame_sync_period_o, d[0] & d[2] ? 6'h10 : 6'h20);
      chk("sync pin", ring_or_delayed_sync_pin_o, d[0] ? i[1] : !i[0]);
      chk("sec req", secondary_request_o, d[0] ? 1'b0 : req_drv);
      chk("pin oe", request_or_ring_pin_oe_o, d[0]);
      chk("chain en", chain_enable_o, d[0]);
      if (d[0])
        chk("ring pin", request_or_ring_pin_o, d[1] ? i[0] : !i[0]);
    end
  endtask
  task t_filter;
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 8'h08 : 8'h18;
      wr(ADDR_FILTER_TYPE_CONTROL, d);
      settle;
      chk("iir", recursive_filter_select_o, d[4]);
      rdc(ADDR_FILTER_TYPE_CONTROL, d);
    end
  endtask
  task t_cal;
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 8'h00 : 8'h7f;
      wr(ADDR_CALIBRATION_CONTROL, d);
      // Trigger stands only in the cycle after the write edge
      chk("cal pulse", manual_cal_trigger_o, d[6]);
      @(negedge clk_i);
      chk("cal pulse end", manual_cal_trigger_o, 1'b0);
      chk("cal off", auto_cal_disable_o, d[5]);
      rdc(ADDR_CALIBRATION_CONTROL, d & 8'h60);
    end
  endtask
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    do_reset(2'h0);
    t_reset;
    t_gain;
    t_fine;
    t_chain;
    t_filter;
    t_cal;
    do_reset(2'h2);
    rdc(ADDR_CHAIN_CONTROL, 8'h3f);
    chk("period", frame_sync_period_o, 8'h10);
    chk("lsb force", serial_out_lsb_force_o, 1'b1);
    chk("slaves", slave_count_o, 3'h1);
    stop_test;
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #100000;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
